// >>> hw/snf_front.sv
`timescale 1ns/10ps
// What this block does
// [R1] Array splits into aligned 64 KiB blocks, each two aligned 32 KiB halves.
// [R2] Smallest unit is a 4 KiB sector; sixteen per block, 2048 in all.
// [R3] Serial clock mode 0 and mode 3 both work; idle level is free.
// [R4] Inputs sampled on rising clock edges; outputs change after falling edges.
// [R5] Dual read and dual identification move two bits per clock on two lines.
// [R6] Quad read variants move four bits per clock on four lines.
// [R7] Quad identification and quad program also use lines two and three.
// [R8] Quad instructions run only while quad wire enable is set.
// [R9] After power-up, only a chip select falling edge selects the device.
// [R10] Power-on reset blocks instructions; state resets when supply comes good.
// [R11] Supply dropping below threshold stops all response until new reset.
// [R12] Host keeps chip select high and no write running at power-down.
// [R13] Active while selected; standby when deselected and no write running.
// [R14] In hold the outputs float and data input and clock are ignored.
// [R15] Hold is entered only while chip select is low.
// [R16] Raising chip select during hold abandons the frame and returns idle.
// [R17] Hold starts when hold input is low while clock is low.
// [R18] Hold ends when hold input is high while clock is low; frame resumes.
// [R19] Bit and byte position are kept across a hold pause.
// [R20] Hold input change during high clock waits for the clock to go low.
// [R21] Hold works only with quad wire enable clear; else pin is data.
// [R22] Deselected: all inputs ignored, all output lines floating.
// [R23] Hold pauses only the serial side; internal write cycles continue.
// [R24] Frame opens with eight-bit code, then 24-bit address, MSB first.
// [R25] Code on the single line; wider lanes only for address and data.
module snf_front (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic supply_ok,
    input wire logic bidir_line_zero_in,
    output logic bidir_line_zero_out,
    output logic bidir_line_zero_oe,
    input wire logic bidir_line_one_in,
    output logic bidir_line_one_out,
    output logic bidir_line_one_oe,
    input wire logic bidir_line_two_in,
    output logic bidir_line_two_out,
    output logic bidir_line_two_oe,
    input wire logic bidir_line_three_in,
    output logic bidir_line_three_out,
    output logic bidir_line_three_oe,
    input wire logic quad_wire_enable,
    input wire logic write_busy,
    output logic active,
    output logic standby,
    output logic hold_active,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic addr_valid,
    output logic [snf_pkg::ADDR_W-1:0] cmd_addr,
    output logic [10:0] addr_sector,
    output logic [7:0] addr_half,
    output logic [6:0] addr_block,
    output logic frame_end,
    output logic rx_overflow,
    output logic [snf_pkg::FIFO_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    import snf_pkg::*;

    typedef struct packed {
        logic [N_SYNC-1:0] s1;
        logic [N_SYNC-1:0] s2;
        logic [N_SYNC-1:0] s3;
        logic [N_SYNC-1:0] f;
        logic [N_SYNC-1:0] pf;
        logic armed;
        logic sel;
        logic hold;
        snf_phase_t phase;
        logic [4:0] cnt;
        snf_dec_t dec;
        logic [7:0] op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] sh;
        logic [7:0] osh;
        logic [2:0] ocnt;
        logic [3:0] dout;
        logic [3:0] oe;
        logic cmd_valid;
        logic addr_valid;
        logic frame_end;
        logic overflow;
        logic [7:0] wdata;
        logic wvalid;
    } snf_state_t;

    snf_state_t st;
    snf_state_t next_st;
    logic [N_SYNC-1:0] pins;
    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fell;
    logic sup_lvl;
    logic fifo_ready;
    logic [7:0] out_byte;
    logic [ADDR_W-1:0] din_wide;

    // *****************************
    // helpers
    // *****************************
    // shift in one clock worth of lanes, line three down to zero, MSB first
    function automatic logic [ADDR_W-1:0] shin(input logic [ADDR_W-1:0] v,
                                               input logic [3:0] io,
                                               input logic [2:0] lanes);
        if (lanes == L4) begin
            shin = {v[ADDR_W-5:0], io};
        end else if (lanes == L2) begin
            shin = {v[ADDR_W-3:0], io[1:0]};
        end else begin
            shin = {v[ADDR_W-2:0], io[0]};
        end
    endfunction

    // clock edges needed to move a number of bits over the lanes
    function automatic logic [4:0] edges(input logic [4:0] bits, input logic [2:0] lanes);
        if (lanes == L4) begin
            edges = bits >> 2;
        end else if (lanes == L2) begin
            edges = bits >> 1;
        end else begin
            edges = bits;
        end
    endfunction

    // lane use per instruction; unknown codes just absorb input bytes
    function automatic snf_dec_t decode(input logic [7:0] op);
        snf_dec_t d;
        d = '{alanes: L1, dlanes: L1, dummy: 5'd0, dir_out: 1'b0, quad: 1'b0, has_addr: 1'b1};
        case (op)
            OP_READ: d.dir_out = 1'b1;
            OP_FAST: begin
                d.dummy = DUMMY_FAST;
                d.dir_out = 1'b1;
            end
            OP_DOR: begin
                d.dummy = DUMMY_FAST;
                d.dlanes = L2;
                d.dir_out = 1'b1;
            end
            OP_DIO, OP_DID: begin
                d = '{alanes: L2, dlanes: L2, dummy: DUMMY_DIO, dir_out: 1'b1,
                      quad: 1'b0, has_addr: 1'b1};
            end
            OP_QOR: begin
                d.dummy = DUMMY_FAST;
                d.dlanes = L4;
                d.dir_out = 1'b1;
                d.quad = 1'b1;
            end
            OP_QIO, OP_QID: begin
                d = '{alanes: L4, dlanes: L4, dummy: DUMMY_QIO, dir_out: 1'b1,
                      quad: 1'b1, has_addr: 1'b1};
            end
            OP_QWR: begin
                d = '{alanes: L4, dlanes: L4, dummy: DUMMY_QWR, dir_out: 1'b1,
                      quad: 1'b1, has_addr: 1'b1};
            end
            OP_QPP: begin
                d.dlanes = L4;
                d.quad = 1'b1;
            end
            OP_PP: d.has_addr = 1'b1;
            default: d.has_addr = 1'b0;
        endcase
        return d;
    endfunction

    // *****************************
    // edge detection on filtered pins
    // *****************************
    assign pins = {supply_ok, bidir_line_three_in, bidir_line_two_in,
                   bidir_line_one_in, bidir_line_zero_in, cs_n, sclk};
    assign sclk_lvl = st.f[IX_SCLK];
    assign sup_lvl = st.f[IX_SUP];
    assign sclk_rise = st.f[IX_SCLK] && !st.pf[IX_SCLK];
    assign sclk_fall = !st.f[IX_SCLK] && st.pf[IX_SCLK];
    assign cs_fell = !st.f[IX_CS] && st.pf[IX_CS];
    // a fresh byte is taken only at a byte boundary while driving out
    assign tx_ready = st.sel && !st.hold && st.phase == PH_DOUT && sclk_fall && st.ocnt == 3'd0;
    assign out_byte = (st.ocnt != 3'd0) ? st.osh : (tx_valid ? tx_data : FILL_BYTE);
    // data bytes shift over the lanes the instruction picked; only the low byte is kept
    assign din_wide = shin({16'h0000, st.sh}, st.f[5:2], st.dec.dlanes);

    // *****************************
    // next state
    // *****************************
    always_comb begin
        next_st = st;
        next_st.cmd_valid = 1'b0;
        next_st.addr_valid = 1'b0;
        next_st.frame_end = 1'b0;
        next_st.wvalid = 1'b0;
        // three stages; a level counts once the last two agree
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.pf = st.f;
        for (int i = 0; i < N_SYNC; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.f[i] = st.s3[i];
            end
        end
        if (!sup_lvl) begin
            next_st.armed = 1'b0; // [R10] [R11]
            next_st.sel = 1'b0;
            next_st.hold = 1'b0;
            next_st.phase = PH_IDLE;
            next_st.oe = 4'h0;
        end else if (st.f[IX_CS]) begin
            // deselect ends the frame even mid-hold
            next_st.armed = 1'b1;
            next_st.frame_end = st.sel;
            next_st.sel = 1'b0; // [R16]
            next_st.hold = 1'b0;
            next_st.phase = PH_IDLE;
            next_st.oe = 4'h0; // [R22]
        end else if (!st.sel) begin
            // a low select seen at power-up never counts as a falling edge
            if (cs_fell && st.armed) begin
                next_st.sel = 1'b1; // [R9] [R3]
                next_st.phase = PH_CMD;
                next_st.cnt = 5'd0;
                next_st.overflow = 1'b0;
            end
        end else begin
            // hold pin follows only with the clock low; quad mode owns the pin
            if (quad_wire_enable) begin
                next_st.hold = 1'b0; // [R21]
            end else if (!sclk_lvl) begin
                next_st.hold = !st.f[IX_IO3]; // [R15] [R17] [R18] [R20]
            end
            if (next_st.hold) begin
                next_st.oe = 4'h0; // [R14]
            end else if (!st.hold && sclk_rise) begin
                // counters stand still in hold, so the frame picks up in place
                case (st.phase) // [R19] [R4]
                    PH_CMD: begin
                        next_st.sh = {st.sh[6:0], st.f[2]}; // [R25]
                        next_st.cnt = st.cnt + 5'd1;
                        if (st.cnt == CMD_BITS - 5'd1) begin
                            next_st.op = next_st.sh;
                            next_st.cmd_valid = 1'b1;
                            next_st.dec = decode(next_st.sh);
                            next_st.cnt = 5'd0;
                            if (next_st.dec.quad && !quad_wire_enable) begin
                                next_st.phase = PH_IGN; // [R8]
                            end else if (next_st.dec.has_addr) begin
                                next_st.phase = PH_ADDR;
                            end else begin
                                next_st.phase = PH_DIN;
                            end
                        end
                    end
                    PH_ADDR: begin
                        next_st.addr = shin(st.addr, st.f[5:2], st.dec.alanes); // [R24]
                        next_st.cnt = st.cnt + 5'd1;
                        if (st.cnt == edges(ADDR_BITS, st.dec.alanes) - 5'd1) begin
                            next_st.addr_valid = 1'b1;
                            next_st.cnt = 5'd0;
                            next_st.ocnt = 3'd0;
                            if (st.dec.dummy != 5'd0) begin
                                next_st.phase = PH_DUMMY;
                            end else begin
                                next_st.phase = st.dec.dir_out ? PH_DOUT : PH_DIN;
                            end
                        end
                    end
                    PH_DUMMY: begin
                        next_st.cnt = st.cnt + 5'd1;
                        if (st.cnt == st.dec.dummy - 5'd1) begin
                            next_st.cnt = 5'd0;
                            next_st.phase = st.dec.dir_out ? PH_DOUT : PH_DIN;
                        end
                    end
                    PH_DIN: begin
                        next_st.sh = din_wide[7:0];
                        next_st.cnt = st.cnt + 5'd1;
                        if (st.cnt == edges(BYTE_BITS, st.dec.dlanes) - 5'd1) begin
                            next_st.cnt = 5'd0;
                            next_st.wdata = next_st.sh; // [R7]
                            next_st.wvalid = 1'b1;
                            // the host cannot be stalled, so a full buffer drops
                            if (!fifo_ready) begin
                                next_st.overflow = 1'b1;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (!st.hold && sclk_fall && st.phase == PH_DOUT) begin
                // drive after the falling edge, top bits on the highest line
                if (st.dec.dlanes == L4) begin
                    next_st.dout = out_byte[7:4]; // [R6]
                    next_st.oe = 4'hF;
                end else if (st.dec.dlanes == L2) begin
                    next_st.dout = {2'b00, out_byte[7:6]}; // [R5]
                    next_st.oe = 4'h3;
                end else begin
                    next_st.dout = {2'b00, out_byte[7], 1'b0};
                    next_st.oe = 4'h2;
                end
                next_st.osh = out_byte << st.dec.dlanes; // [R4]
                next_st.ocnt = st.ocnt + st.dec.dlanes;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // *****************************
    // received data buffer
    // *****************************
    snf_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data(st.wdata),
        .in_valid(st.wvalid),
        .in_ready(fifo_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // *****************************
    // outputs
    // *****************************
    assign {bidir_line_three_out, bidir_line_two_out} = st.dout[3:2];
    assign {bidir_line_one_out, bidir_line_zero_out} = st.dout[1:0];
    assign {bidir_line_three_oe, bidir_line_two_oe} = st.oe[3:2];
    assign {bidir_line_one_oe, bidir_line_zero_oe} = st.oe[1:0];
    // write cycles run on regardless of hold or select
    assign active = st.sel; // [R13] [R23]
    assign standby = !st.sel && !write_busy; // [R13]
    assign hold_active = st.hold;
    assign cmd_valid = st.cmd_valid;
    assign cmd_code = st.op;
    assign addr_valid = st.addr_valid;
    assign cmd_addr = st.addr;
    assign addr_sector = st.addr[ARRAY_MSB:SECTOR_LSB]; // [R2]
    assign addr_half = st.addr[ARRAY_MSB:HALF_LSB]; // [R1]
    assign addr_block = st.addr[ARRAY_MSB:BLOCK_LSB]; // [R1]
    assign frame_end = st.frame_end;
    assign rx_overflow = st.overflow;

    // *****************************
    // checks
    // *****************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_fall_drive;
        $changed(st.dout) |-> $past(sclk_fall);
    endproperty
    a_fall_drive: assert property (p_fall_drive) else $error("output moved off a fall"); // [R4]
    property p_dual_lanes;
        (st.phase == PH_DOUT && st.dec.dlanes == L2 && st.oe != 4'h0) |-> st.oe == 4'h3;
    endproperty
    a_dual_lanes: assert property (p_dual_lanes) else $error("dual lane enables wrong"); // [R5]
    property p_quad_lanes;
        (st.phase == PH_DOUT && st.dec.dlanes == L4 && st.oe != 4'h0) |-> st.oe == 4'hF;
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad lane enables wrong"); // [R6]
    property p_qpp_lanes;
        (st.wvalid && st.op == OP_QPP) |-> st.dec.dlanes == L4 && $past(st.cnt) == 5'd1;
    endproperty
    a_qpp_lanes: assert property (p_qpp_lanes) else $error("quad program not four wide"); // [R7]
    property p_quad_gate;
        (st.cmd_valid && decode(st.op).quad && !$past(quad_wire_enable))
            |-> st.phase == PH_IGN ##1 !st.addr_valid;
    endproperty
    a_quad_gate: assert property (p_quad_gate) else $error("quad code ran while disabled"); // [R8]
    property p_select_edge;
        $rose(st.sel) |-> $past(st.armed) && $past(cs_fell);
    endproperty
    a_select_edge: assert property (p_select_edge) else $error("select without a fall"); // [R9]
    property p_supply;
        !sup_lvl |=> !st.sel && !st.armed;
    endproperty
    a_supply: assert property (p_supply) else $error("responding under low supply"); // [R11]
    property p_hold_float;
        st.hold |-> st.oe == 4'h0 && !tx_ready;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("driving while held"); // [R14]
    property p_cs_float;
        !st.sel |-> st.oe == 4'h0;
    endproperty
    a_cs_float: assert property (p_cs_float) else $error("driving while deselected"); // [R22]
    property p_hold_enter;
        $rose(st.hold) |-> !$past(sclk_lvl) && st.sel;
    endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("hold began with clock high"); // [R17]
    property p_hold_exit;
        $fell(st.hold) |-> !$past(sclk_lvl) || !st.sel || $past(quad_wire_enable);
    endproperty
    a_hold_exit: assert property (p_hold_exit) else $error("hold ended with clock high"); // [R18]
    property p_hold_keep;
        (st.hold ##1 st.sel) |-> $stable(st.cnt) && $stable(st.phase) && $stable(st.sh);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("position moved during hold"); // [R19]
    property p_desel_idle;
        $fell(st.sel) |-> st.phase == PH_IDLE && !st.hold;
    endproperty
    a_desel_idle: assert property (p_desel_idle) else $error("frame not abandoned"); // [R16]
    property p_hold_qe;
        $past(quad_wire_enable) |-> !st.hold;
    endproperty
    a_hold_qe: assert property (p_hold_qe) else $error("hold in quad mode"); // [R21]

    c_quad_read: cover property (st.phase == PH_DOUT && st.dec.dlanes == L4 && st.oe == 4'hF);
    c_hold: cover property ($rose(st.hold) ##[1:200] $fell(st.hold) && st.sel);
    c_hold_abort: cover property (st.hold ##1 !st.sel);
    c_program: cover property (st.wvalid && st.op == OP_PP);
endmodule

// >>> hw/snf_pkg.sv
package snf_pkg;
    // *****************************
    // instruction codes
    // *****************************
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_DOR = 8'h3B;
    localparam logic [7:0] OP_DIO = 8'hBB;
    localparam logic [7:0] OP_DID = 8'h92;
    localparam logic [7:0] OP_QOR = 8'h6B;
    localparam logic [7:0] OP_QIO = 8'hEB;
    localparam logic [7:0] OP_QWR = 8'hE7;
    localparam logic [7:0] OP_QID = 8'h94;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] FILL_BYTE = 8'hFF;

    // *****************************
    // array map and frame layout
    // *****************************
    localparam int ADDR_W = 24;
    localparam int ARRAY_MSB = 22;
    localparam int SECTOR_LSB = 12;
    localparam int HALF_LSB = 15;
    localparam int BLOCK_LSB = 16;
    localparam logic [4:0] CMD_BITS = 5'd8;
    localparam logic [4:0] ADDR_BITS = 5'd24;
    localparam logic [4:0] BYTE_BITS = 5'd8;
    localparam logic [4:0] DUMMY_FAST = 5'd8;
    localparam logic [4:0] DUMMY_DIO = 5'd4;
    localparam logic [4:0] DUMMY_QIO = 5'd6;
    localparam logic [4:0] DUMMY_QWR = 5'd4;
    localparam logic [2:0] L1 = 3'd1;
    localparam logic [2:0] L2 = 3'd2;
    localparam logic [2:0] L4 = 3'd4;

    // *****************************
    // input sampling and buffering
    // *****************************
    localparam int N_SYNC = 7;
    localparam int IX_SCLK = 0;
    localparam int IX_CS = 1;
    localparam int IX_IO3 = 5;
    localparam int IX_SUP = 6;
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CMD = 3'b001,
        PH_ADDR = 3'b010,
        PH_DUMMY = 3'b011,
        PH_DOUT = 3'b100,
        PH_DIN = 3'b101,
        PH_IGN = 3'b110
    } snf_phase_t;

    typedef struct packed {
        logic [2:0] alanes;
        logic [2:0] dlanes;
        logic [4:0] dummy;
        logic dir_out;
        logic quad;
        logic has_addr;
    } snf_dec_t;
endpackage

// >>> hw/snf_fifo.sv
`timescale 1ns/10ps
module snf_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } snf_fifo_st_t;

    snf_fifo_st_t st;
    snf_fifo_st_t next_st;
    logic push;
    logic pop;

    // full and empty straight from the fill count
    assign in_ready = st.cnt != (AW+1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointers wrap naturally since depth is a power of two
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> verif/snf_host.sv
`timescale 1ns/10ps
// *****
// spi host model, clock mode 0
// *****
module snf_host (
    input wire logic ref_clk,
    input wire logic miso,
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    logic [7:0] got;
    // idle deselected with clock low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // bit set while clock low, read late in high half for margin
    task automatic xfer(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            mosi = b[i];
            repeat (4) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            got[i] = miso;
            sclk = 1'b0;
        end
    endtask
    // select stays low for the whole frame
    task automatic sel(input logic on);
        repeat (8) @(negedge ref_clk);
        cs_n = ~on;
    endtask
endmodule

// >>> verif/snf_tb_top.sv
`timescale 1ns/10ps
module serial_nor_flash_bus_front_end_tb_top;
    import snf_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, write_busy = 1'b0, rx_ready = 1'b0;
    logic sclk, cs_n, mosi, z_out, z_oe, o_out, o_oe, cmd_valid, addr_valid, rx_valid;
    logic active, standby;
    logic sup_ok = 1'b1, quad_en = 1'b0, tx_valid = 1'b1, wp_n = 1'b1, hold_n = 1'b1;
    logic [7:0] cmd_code, rx_data, tx_data = 8'h00;
    logic [23:0] cmd_addr, a, m, ma, notes[$];
    logic [10:0] addr_sector;
    logic [7:0] addr_half;
    logic [6:0] addr_block;
    integer seed = 32'h6e4f;
    int errors = 0, total_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    // released lines show a changing pattern, not the last bit
    snf_host host (.ref_clk(ref_clk), .miso(o_oe ? o_out : ~mosi), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi));
    snf_front DUT (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .supply_ok(sup_ok),
        .bidir_line_zero_in(z_oe ? z_out : mosi), .bidir_line_zero_out(z_out),
        .bidir_line_zero_oe(z_oe), .bidir_line_one_in(o_oe ? o_out : ~mosi),
        .bidir_line_one_out(o_out), .bidir_line_one_oe(o_oe), .bidir_line_two_in(wp_n),
        .bidir_line_two_out(), .bidir_line_two_oe(), .bidir_line_three_in(hold_n),
        .bidir_line_three_out(), .bidir_line_three_oe(), .quad_wire_enable(quad_en),
        .write_busy(write_busy), .active(active), .standby(standby), .hold_active(),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .addr_valid(addr_valid),
        .cmd_addr(cmd_addr), .addr_sector(addr_sector), .addr_half(addr_half),
        .addr_block(addr_block), .frame_end(), .rx_overflow(), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready());
    task automatic check(input string n, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // random drain stalls on the fifo output
    always @(negedge ref_clk) rx_ready <= 1'($random(seed));
    // each result takes the oldest note
    always @(posedge ref_clk) begin
        if (cmd_valid) check("cmd_code", {16'h0000, cmd_code}, notes.pop_front());
        if (addr_valid) begin
            ma = notes.pop_front();
            check("cmd_addr", cmd_addr, ma);
            check("sector", {13'h0000, addr_sector}, {13'h0000, ma[22:12]});
            check("half", {16'h0000, addr_half}, {16'h0000, ma[22:15]});
            check("block", {17'h00000, addr_block}, {17'h00000, ma[22:16]});
        end
        if (rx_valid && rx_ready) check("rx_data", {16'h0000, rx_data}, notes.pop_front());
    end
    // *****
    // main sequence: read frame, then program frame
    // *****
    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        check("standby", {23'h000000, standby}, 24'h000001);
        a = 24'($random(seed)) & 24'h7FFFFF;
        tx_data = 8'($random(seed));
        notes.push_back({16'h0000, OP_READ});
        notes.push_back(a);
        host.sel(1'b1);
        repeat (8) @(negedge ref_clk);
        check("active", {23'h000000, active}, 24'h000001);
        host.xfer(OP_READ);
        for (int i = 2; i >= 0; i--) host.xfer(a[8*i +: 8]);
        host.xfer(8'h00);
        check("tx_byte", {16'h0000, host.got}, {16'h0000, tx_data});
        host.sel(1'b0);
        write_busy = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("standby", {23'h000000, standby}, 24'h000000);
        write_busy = 1'b0;
        a = 24'($random(seed)) & 24'h7FFFFF;
        notes.push_back({16'h0000, OP_PP});
        notes.push_back(a);
        host.sel(1'b1);
        host.xfer(OP_PP);
        for (int i = 2; i >= 0; i--) host.xfer(a[8*i +: 8]);
        for (int i = 0; i < 2; i++) begin
            m = 24'($random(seed)) & 24'h0000FF;
            notes.push_back(m);
            host.xfer(m[7:0]);
        end
        host.sel(1'b0);
        // supply drop while selected must drop the selection
        host.sel(1'b1);
        repeat (8) @(negedge ref_clk);
        sup_ok = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("active_low_supply", {23'h000000, active}, 24'h000000);
        sup_ok = 1'b1;
        host.sel(1'b0);
        for (int k = 0; k < 2000 && notes.size() > 0; k++) @(negedge ref_clk);
        if (notes.size() > 0) errors++;
        complete_run();
    end
    // hang guard
    initial begin
        #2000000;
        errors++;
        complete_run();
    end
endmodule
